// ===== rtl/accel_mode_pkg.sv
// constants, field layout and types shared by the operating-mode controller
package accel_mode_pkg;
   // clock and time base
   localparam int unsigned CLK_HZ = 50_000_000; // system clock rate
   localparam int unsigned MS_PER_S = 1000; // milliseconds per second
   localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S; // cycles in one millisecond
   // filter settling periods in ms
   localparam int unsigned SETTLE_SHORT_MS = 16; // filters bypassed
   localparam int unsigned SETTLE_LONG_MS = 370; // default, filters in use
   // sleep intervals in ms, indexed by the sleep interval field
   localparam int unsigned SLEEP_MS [8] = '{52, 104, 208, 512, 2048, 4096, 8192, 24576};
   // apb register byte offsets
   localparam int unsigned ADDR_W = 8; // decoded address width
   localparam logic [7:0] OFF_POWER = 8'h00; // power mode register
   localparam logic [7:0] OFF_TIMING = 8'h04; // sleep interval register
   localparam logic [7:0] OFF_STATE = 8'h08; // controller state, read only
   localparam logic [7:0] OFF_INT_STATUS = 8'h0c; // sticky events, write one to clear
   localparam logic [7:0] OFF_INT_MASK = 8'h10; // interrupt enables
   // power mode register layout
   localparam int unsigned POW_W = 8; // implemented width
   localparam int unsigned POW_MODE_LSB = 0; // mode field
   localparam int unsigned POW_MODE_W = 2; // mode field width
   localparam int unsigned POW_SETTLE_BIT = 2; // settle time select, 1 = short
   localparam int unsigned POW_HIRANGE_BIT = 3; // raise impact threshold
   localparam int unsigned POW_ACTION_LSB = 4; // wake-up motion action
   localparam int unsigned POW_ACTION_W = 2; // action field width
   localparam int unsigned POW_EXTCLK_BIT = 6; // first pin takes external clock
   localparam int unsigned POW_SYNC_BIT = 7; // second pin takes sync trigger
   localparam logic [7:0] POW_RST = 8'h00; // standby, long settle, low threshold
   // timing register layout
   localparam int unsigned SLEEP_W = 3; // sleep interval field width
   localparam logic [2:0] SLEEP_RST = 3'h0; // shortest interval
   // state register layout
   localparam int unsigned ST_CODE_W = 3; // state code width
   localparam int unsigned ST_ALERT_BIT = 3; // host alert level
   localparam int unsigned ST_DSWAKE_BIT = 4; // downstream wake level
   localparam int unsigned ST_SENSOR_BIT = 5; // front end powered
   // interrupt status layout
   localparam int unsigned INT_W = 3; // number of event bits
   localparam int unsigned INT_DATA_BIT = 0; // new sample produced
   localparam int unsigned INT_IMPACT_BIT = 1; // impact woke instant-on
   localparam int unsigned INT_SETTLED_BIT = 2; // settling finished
   localparam logic [2:0] INT_RST = 3'h0; // nothing pending
   // operating modes as written by software
   typedef enum logic [1:0] {
      MODE_STANDBY = 2'h0,
      MODE_INSTANT = 2'h1,
      MODE_WAKE = 2'h2,
      MODE_MEASURE = 2'h3
   } mode_t;
   // wake-up motion responses
   typedef enum logic [1:0] {
      ACT_MEASURE = 2'h0,
      ACT_HOST = 2'h1,
      ACT_DOWNSTREAM = 2'h2
   } action_t;
   // controller states, gray along standby-settle-measure-instant-wake
   typedef enum logic [2:0] {
      ST_STANDBY = 3'h0,
      ST_SETTLE = 3'h1,
      ST_MEASURE = 3'h3,
      ST_INSTANT = 3'h2,
      ST_WAKE_SLEEP = 3'h6,
      ST_WAKE_SETTLE = 3'h7
   } state_t;
endpackage

// ===== rtl/pin_sync3.sv
// three-stage pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/100ps
module pin_sync3 (
   input wire logic clk_i, // system clock
   input wire logic rst_i, // async reset, active high
   input wire logic pin_i, // raw asynchronous pin
   output logic level_o, // filtered level
   output logic rise_o // one-cycle pulse on accepted rise
);
   logic meta; // first stage, read only by the second
   logic s2; // second stage
   logic s3; // third stage

   // shift chain; the first flop feeds nothing but s2
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end
      else
      begin
         meta <= pin_i;
         s2 <= meta;
         s3 <= s2;
      end
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         level_o <= 1'b0;
         rise_o <= 1'b0;
      end
      else
      begin
         rise_o <= (s2 == s3) && s2 && !level_o;
         if (s2 == s3)
         begin
            level_o <= s2;
         end
      end
   end
endmodule

// ===== rtl/accel_mode_ctrl.sv
// operating-mode controller: standby, measurement, instant-on and wake-up sequencing
`timescale 1ns/100ps
module accel_mode_ctrl #(
   parameter int unsigned DATA_W = 12, // sample width
   parameter int unsigned CYCLES_PER_MS = accel_mode_pkg::CYC_PER_MS // shrink in simulation
) (
   input wire logic clk_i, // system clock, 50 mhz
   input wire logic rst_i, // async reset, active high
   input wire logic psel_i, // apb select
   input wire logic penable_i, // apb access phase
   input wire logic pwrite_i, // apb direction, 1 = write
   input wire logic [accel_mode_pkg::ADDR_W-1:0] paddr_i, // apb byte address
   input wire logic [31:0] pwdata_i, // apb write data
   output logic [31:0] prdata_o, // apb read data
   output logic pready_o, // apb ready, always one
   output logic pslverr_o, // apb error on unmapped address
   input wire logic impact_lo_i, // comparator over low impact level
   input wire logic impact_hi_i, // comparator over high impact level
   input wire logic motion_i, // low-g activity detected
   input wire logic sample_tick_i, // internal conversion strobe
   input wire logic [DATA_W-1:0] sample_i, // converted sample
   output logic [DATA_W-1:0] data_o, // output data register
   output logic fifo_wr_o, // one-cycle fifo write strobe
   output logic sensor_on_o, // front end powered
   output logic host_alert_o, // motion alert level to host
   output logic downstream_wake_o, // wake level for downstream circuits
   output logic irq_o, // level interrupt
   input wire logic first_interrupt_pin_i, // first pin, input side
   output logic first_interrupt_pin_o, // first pin, output value
   output logic first_interrupt_pin_oe_n_o, // first pin, drive when low
   input wire logic second_interrupt_pin_i, // second pin, input side
   output logic second_interrupt_pin_o, // second pin, output value
   output logic second_interrupt_pin_oe_n_o, // second pin, drive when low
   input wire logic i2c_sel_i, // serial port uses i2c protocol
   input wire logic mosi_sda_i, // shared data-in pin
   input wire logic cs_scl_i, // shared select/clock pin
   output logic spi_mosi_o, // spi data to serial engine
   output logic spi_cs_n_o, // spi select to serial engine
   output logic i2c_sda_o, // i2c data to serial engine
   output logic i2c_scl_o // i2c clock to serial engine
);
   accel_mode_pkg::state_t state; // current controller state
   accel_mode_pkg::state_t next_state; // state for the next edge
   logic [accel_mode_pkg::POW_W-1:0] power_mode_register; // mode and options
   logic [accel_mode_pkg::SLEEP_W-1:0] sleep_interval_field; // sleep select
   logic [accel_mode_pkg::INT_W-1:0] int_status; // sticky events
   logic [accel_mode_pkg::INT_W-1:0] int_mask; // event enables
   logic [accel_mode_pkg::INT_W-1:0] events; // this cycle's events
   logic [31:0] timer; // settle and sleep down-counter
   logic [31:0] timer_load; // value loaded on state entry
   logic timer_done; // counter reached zero
   logic apb_acc; // access phase of any transfer
   logic wr_en; // completed write
   logic mapped; // address hits a register
   logic mode_wr; // write to the power mode register
   accel_mode_pkg::mode_t wr_mode; // mode being written
   logic settle_time_select; // 1 = short settling
   logic settle_pick; // settle choice in force for a timer load
   logic hi_range; // high impact threshold
   accel_mode_pkg::action_t wake_action; // motion response
   logic ext_clk_en; // first pin is a clock input
   logic sync_en; // second pin is a trigger input
   logic impact_hit; // impact over chosen threshold
   logic tick; // sample moment
   logic clk_pin_rise; // external clock edge
   logic sync_pin_rise; // sync trigger edge
   logic irq_allowed; // state permits interrupts

   // sleep interval in cycles
   function automatic logic [31:0] sleep_cycles(input logic [2:0] sel);
      sleep_cycles = 32'(accel_mode_pkg::SLEEP_MS[sel] * CYCLES_PER_MS);
   endfunction

   // settling period in cycles, short or long
   function automatic logic [31:0] settle_cycles(input logic short_sel);
      settle_cycles = short_sel ? 32'(accel_mode_pkg::SETTLE_SHORT_MS * CYCLES_PER_MS)
                                : 32'(accel_mode_pkg::SETTLE_LONG_MS * CYCLES_PER_MS);
   endfunction

   // state entered on a mode write
   function automatic accel_mode_pkg::state_t mode_target(input accel_mode_pkg::mode_t m);
      unique case (m)
         accel_mode_pkg::MODE_STANDBY: mode_target = accel_mode_pkg::ST_STANDBY;
         accel_mode_pkg::MODE_INSTANT: mode_target = accel_mode_pkg::ST_INSTANT;
         accel_mode_pkg::MODE_WAKE: mode_target = accel_mode_pkg::ST_WAKE_SLEEP;
         accel_mode_pkg::MODE_MEASURE: mode_target = accel_mode_pkg::ST_SETTLE;
      endcase
   endfunction

   // option fields of the power mode register
   assign settle_time_select = power_mode_register[accel_mode_pkg::POW_SETTLE_BIT];
   assign hi_range = power_mode_register[accel_mode_pkg::POW_HIRANGE_BIT];
   assign wake_action = accel_mode_pkg::action_t'(
      power_mode_register[accel_mode_pkg::POW_ACTION_LSB +: accel_mode_pkg::POW_ACTION_W]);
   assign ext_clk_en = power_mode_register[accel_mode_pkg::POW_EXTCLK_BIT];
   assign sync_en = power_mode_register[accel_mode_pkg::POW_SYNC_BIT];
   // a mode write loads the timer with the settle choice written alongside it,
   // since the register itself only takes that value at the same edge
   assign settle_pick = mode_wr ? pwdata_i[accel_mode_pkg::POW_SETTLE_BIT] : settle_time_select;

   // apb decode; zero wait states keeps the bus simple
   assign apb_acc = psel_i && penable_i;
   assign wr_en = apb_acc && pwrite_i;
   assign mapped = (paddr_i == accel_mode_pkg::OFF_POWER) ||
                   (paddr_i == accel_mode_pkg::OFF_TIMING) ||
                   (paddr_i == accel_mode_pkg::OFF_STATE) ||
                   (paddr_i == accel_mode_pkg::OFF_INT_STATUS) ||
                   (paddr_i == accel_mode_pkg::OFF_INT_MASK);
   assign pready_o = 1'b1;
   assign pslverr_o = apb_acc && !mapped;
   // mode change taken at write completion
   assign mode_wr = wr_en && (paddr_i == accel_mode_pkg::OFF_POWER);
   assign wr_mode = accel_mode_pkg::mode_t'(
      pwdata_i[accel_mode_pkg::POW_MODE_LSB +: accel_mode_pkg::POW_MODE_W]);

   // read mux; unused upper bits read zero
   always_comb
   begin
      prdata_o = 32'h0;
      if (apb_acc && !pwrite_i)
      begin
         unique case (paddr_i)
            accel_mode_pkg::OFF_POWER: prdata_o = 32'(power_mode_register);
            accel_mode_pkg::OFF_TIMING: prdata_o = 32'(sleep_interval_field);
            accel_mode_pkg::OFF_STATE:
            begin
               prdata_o[accel_mode_pkg::ST_CODE_W-1:0] = state;
               prdata_o[accel_mode_pkg::ST_ALERT_BIT] = host_alert_o;
               prdata_o[accel_mode_pkg::ST_DSWAKE_BIT] = downstream_wake_o;
               prdata_o[accel_mode_pkg::ST_SENSOR_BIT] = sensor_on_o;
            end
            accel_mode_pkg::OFF_INT_STATUS: prdata_o = 32'(int_status);
            accel_mode_pkg::OFF_INT_MASK: prdata_o = 32'(int_mask);
            default: prdata_o = 32'h0;
         endcase
      end
   end

   // configuration stays writable in every state
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         power_mode_register <= accel_mode_pkg::POW_RST;
         sleep_interval_field <= accel_mode_pkg::SLEEP_RST;
         int_mask <= accel_mode_pkg::INT_RST;
      end
      else if (wr_en)
      begin
         if (paddr_i == accel_mode_pkg::OFF_POWER)
         begin
            power_mode_register <= pwdata_i[accel_mode_pkg::POW_W-1:0];
         end
         if (paddr_i == accel_mode_pkg::OFF_TIMING)
         begin
            sleep_interval_field <= pwdata_i[accel_mode_pkg::SLEEP_W-1:0];
         end
         if (paddr_i == accel_mode_pkg::OFF_INT_MASK)
         begin
            int_mask <= pwdata_i[accel_mode_pkg::INT_W-1:0];
         end
      end
   end

   // pin inputs cross in through the three-flop filter
   pin_sync3 u_clk_pin (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(first_interrupt_pin_i),
      .level_o(),
      .rise_o(clk_pin_rise)
   );

   pin_sync3 u_sync_pin (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(second_interrupt_pin_i),
      .level_o(),
      .rise_o(sync_pin_rise)
   );

   // external clock replaces internal sample strobe
   // sync trigger edge takes over sampling when enabled, ahead of the external clock
   assign tick = sync_en ? sync_pin_rise : (ext_clk_en ? clk_pin_rise : sample_tick_i);

   assign impact_hit = hi_range ? impact_hi_i : impact_lo_i;

   assign timer_done = (timer == 32'h0);

   always_comb
   begin
      next_state = state;
      if (mode_wr)
      begin
         next_state = mode_target(wr_mode);
      end
      else
      begin
         unique case (state)
            accel_mode_pkg::ST_STANDBY: next_state = state; // waits for host
            accel_mode_pkg::ST_SETTLE:
               if (timer_done) next_state = accel_mode_pkg::ST_MEASURE;
            accel_mode_pkg::ST_MEASURE: next_state = state;
            accel_mode_pkg::ST_INSTANT:
               if (impact_hit) next_state = accel_mode_pkg::ST_MEASURE;
            accel_mode_pkg::ST_WAKE_SLEEP:
               if (timer_done) next_state = accel_mode_pkg::ST_WAKE_SETTLE;
            accel_mode_pkg::ST_WAKE_SETTLE:
               // motion may switch to full measurement
               if (motion_i && wake_action == accel_mode_pkg::ACT_MEASURE)
                  next_state = accel_mode_pkg::ST_MEASURE;
               else if (timer_done)
                  next_state = accel_mode_pkg::ST_WAKE_SLEEP;
            default: next_state = accel_mode_pkg::ST_STANDBY; // illegal codes recover
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         state <= accel_mode_pkg::ST_STANDBY;
      else
         state <= next_state;
   end

   always_comb
   begin
      timer_load = 32'h0;
      if (next_state == accel_mode_pkg::ST_WAKE_SLEEP)
         timer_load = sleep_cycles(sleep_interval_field);
      else if (next_state == accel_mode_pkg::ST_SETTLE ||
               next_state == accel_mode_pkg::ST_WAKE_SETTLE)
         timer_load = settle_cycles(settle_pick);
   end

   // timer reloads on every state entry, so a mode rewrite restarts it
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         timer <= 32'h0;
      else if (next_state != state || mode_wr)
         timer <= timer_load;
      else if (!timer_done)
         timer <= timer - 32'h1;
   end

   // front end powered except in standby and wake-up sleep
   assign sensor_on_o = (state != accel_mode_pkg::ST_STANDBY) &&
                        (state != accel_mode_pkg::ST_WAKE_SLEEP);

   // data path: full rate in measurement, one sample per wake period
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         data_o <= '0;
         fifo_wr_o <= 1'b0;
      end
      else
      begin
         fifo_wr_o <= (state == accel_mode_pkg::ST_MEASURE) && tick;
         if (state == accel_mode_pkg::ST_MEASURE && tick)
            data_o <= sample_i;
         // wake-up refresh at end of settling
         else if (state == accel_mode_pkg::ST_WAKE_SETTLE && timer_done)
            data_o <= sample_i;
      end
   end

   // wake-up motion responses, held until the next mode write
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         host_alert_o <= 1'b0;
         downstream_wake_o <= 1'b0;
      end
      else if (mode_wr)
      begin
         host_alert_o <= 1'b0;
         downstream_wake_o <= 1'b0;
      end
      else if (state == accel_mode_pkg::ST_WAKE_SETTLE && motion_i)
      begin
         if (wake_action == accel_mode_pkg::ACT_HOST)
            host_alert_o <= 1'b1;
         if (wake_action == accel_mode_pkg::ACT_DOWNSTREAM)
            downstream_wake_o <= 1'b1;
      end
   end

   // no interrupt sources in wake-up or standby
   assign irq_allowed = (state == accel_mode_pkg::ST_SETTLE) ||
                        (state == accel_mode_pkg::ST_MEASURE) ||
                        (state == accel_mode_pkg::ST_INSTANT);

   // event vector, each guarded against a coinciding mode write
   always_comb
   begin
      events = '0;
      events[accel_mode_pkg::INT_DATA_BIT] = (state == accel_mode_pkg::ST_MEASURE) && tick;
      events[accel_mode_pkg::INT_IMPACT_BIT] = (state == accel_mode_pkg::ST_INSTANT) &&
                                               impact_hit;
      events[accel_mode_pkg::INT_SETTLED_BIT] = (state == accel_mode_pkg::ST_SETTLE) &&
                                                timer_done;
      if (mode_wr || !irq_allowed)
         events = '0;
   end

   // sticky status; a set beats a same-cycle write-one clear
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         int_status <= accel_mode_pkg::INT_RST;
      else if (next_state == accel_mode_pkg::ST_STANDBY)
         int_status <= accel_mode_pkg::INT_RST;
      else if (wr_en && paddr_i == accel_mode_pkg::OFF_INT_STATUS)
         int_status <= (int_status & ~pwdata_i[accel_mode_pkg::INT_W-1:0]) | events;
      else
         int_status <= int_status | events;
   end

   // interrupt line gated outside active states
   assign irq_o = irq_allowed && |(int_status & int_mask);

   // first pin released when used as clock input
   assign first_interrupt_pin_o = irq_o;
   assign first_interrupt_pin_oe_n_o = ext_clk_en;
   // second pin released when used as sync input
   assign second_interrupt_pin_o = irq_o;
   assign second_interrupt_pin_oe_n_o = sync_en;

   // shared serial pins routed by protocol, idle side parked
   assign spi_mosi_o = i2c_sel_i ? 1'b0 : mosi_sda_i;
   assign spi_cs_n_o = i2c_sel_i ? 1'b1 : cs_scl_i;
   assign i2c_sda_o = i2c_sel_i ? mosi_sda_i : 1'b1;
   assign i2c_scl_o = i2c_sel_i ? cs_scl_i : 1'b1;

   // checks on the sequencing
   standby_quiet_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (state == accel_mode_pkg::ST_STANDBY) |-> (!irq_o && int_status == '0))
      else $error("interrupt pending in standby");

   wake_no_fifo_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (state == accel_mode_pkg::ST_WAKE_SLEEP || state == accel_mode_pkg::ST_WAKE_SETTLE)
      |-> !irq_o ##1 !fifo_wr_o)
      else $error("fifo write or interrupt in wake-up");

   reset_standby_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> (state == accel_mode_pkg::ST_STANDBY && !sensor_on_o))
      else $error("not in standby after reset");

   impact_wake_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (state == accel_mode_pkg::ST_INSTANT && impact_hit && !mode_wr)
      |=> (state == accel_mode_pkg::ST_MEASURE && int_status[accel_mode_pkg::INT_IMPACT_BIT]))
      else $error("impact did not start measurement");

   settle_hold_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (state == accel_mode_pkg::ST_SETTLE) |=> (!fifo_wr_o && $stable(data_o)))
      else $error("sample released during settling");

   mode_apply_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (mode_wr && wr_mode == accel_mode_pkg::MODE_STANDBY) |=>
      (state == accel_mode_pkg::ST_STANDBY))
      else $error("standby write not applied");

   instant_freeze_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (state == accel_mode_pkg::ST_INSTANT && $past(state) == accel_mode_pkg::ST_INSTANT)
      |-> $stable(data_o))
      else $error("data changed in instant-on");

   measure_data_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (state == accel_mode_pkg::ST_MEASURE && tick) |=> (fifo_wr_o && data_o == $past(sample_i)))
      else $error("measurement sample lost");
endmodule

// ===== tb/ext_clock_model.sv
// external sample clock source for the first interrupt pin
`timescale 1ns/100ps
module ext_clock_model (
   input wire logic run_i, // start a clock burst
   output logic clk_o // clock toward the pin, rests low
);
   // 160 ns period, still between bursts so no stray edge is counted
   // external clock source
   always
   begin
      clk_o = 1'b0;
      wait (run_i);
      #80 clk_o = 1'b1;
      #80;
   end
endmodule

// ===== tb/accel_operating_mode_control_bench.sv
// bench for the operating-mode controller, driven over apb
`timescale 1ns/100ps
module accel_operating_mode_control_bench;
   logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, run = 0, err;
   logic impact_lo_i = 0, impact_hi_i = 0, motion_i = 0, sample_tick_i = 0, i2c_sel_i = 0;
   logic mosi_sda_i = 0, cs_scl_i = 1, pready_o, pslverr_o, fifo_wr_o, sensor_on_o, irq_o;
   logic host_alert_o, downstream_wake_o, first_interrupt_pin_o, first_interrupt_pin_oe_n_o;
   logic second_interrupt_pin_o, second_interrupt_pin_oe_n_o, spi_mosi_o, spi_cs_n_o, ext_clk;
   logic i2c_sda_o, i2c_scl_o, sync_pin = 0; // sync_pin: host trigger toward the second pin
   logic [7:0] paddr_i = 0; // apb address
   logic [31:0] pwdata_i = 0, prdata_o, q; // apb data and last read
   logic [11:0] sample_i = 0, data_o; // sample path
   int failures = 0, num_checks = 0, cyc = 0;
   // pins resolve to whoever drives; a released second pin follows the host trigger
   wire logic first_interrupt_pin_i = first_interrupt_pin_oe_n_o ? ext_clk : first_interrupt_pin_o;
   wire logic second_interrupt_pin_i = second_interrupt_pin_oe_n_o ? sync_pin :
      second_interrupt_pin_o;
   accel_mode_ctrl #(.CYCLES_PER_MS(2)) i_accel_mode_ctrl (.clk_i, .rst_i, .psel_i, .penable_i,
      .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .impact_lo_i, .impact_hi_i,
      .motion_i, .sample_tick_i, .sample_i, .data_o, .fifo_wr_o, .sensor_on_o, .host_alert_o,
      .downstream_wake_o, .irq_o, .first_interrupt_pin_i, .first_interrupt_pin_o,
      .first_interrupt_pin_oe_n_o, .second_interrupt_pin_i, .second_interrupt_pin_o,
      .second_interrupt_pin_oe_n_o, .i2c_sel_i, .mosi_sda_i, .cs_scl_i, .spi_mosi_o, .spi_cs_n_o,
      .i2c_sda_o, .i2c_scl_o);
   ext_clock_model i_ext_clock_model (.run_i(run), .clk_o(ext_clk));
   // 50 mhz clock
   always #10 clk_i = ~clk_i;
   // verdict and end of run
   task automatic wrap_up();
      if (failures == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // hang guard, well above the planned run length
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         failures++;
         wrap_up();
      end
   end
   // compare and report
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   // one apb transfer; starts on a fresh edge so release and setup never collide
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_i <= 1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1;
      @(posedge clk_i);
      while (pready_o !== 1'b1)
         @(posedge clk_i);
      q = prdata_o;
      err = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
   endtask
   // main sequence
   initial
   begin
      repeat (8) @(posedge clk_i);
      rst_i <= 0;
      apb(0, 8'h08, 0); check("state after reset", q, 32'h0);
      apb(0, 8'h14, 0); check("unmapped error", err, 1);
      apb(1, 8'h00, 32'h07); apb(0, 8'h08, 0); check("settling", q, 32'h21);
      repeat (40) @(posedge clk_i);
      apb(0, 8'h08, 0); check("measuring", q, 32'h23);
      sample_i <= 12'h5a3;
      sample_tick_i <= 1;
      @(posedge clk_i);
      sample_tick_i <= 0;
      #1 check("fifo write", fifo_wr_o, 1);
      check("data out", data_o, 12'h5a3);
      apb(1, 8'h10, 32'h05); #1 check("irq raised", irq_o, 1);
      apb(1, 8'h0c, 32'h01); apb(0, 8'h0c, 0); check("w1c status", q, 32'h4);
      apb(1, 8'h00, 32'h00); #1 check("standby irq", irq_o, 0);
      apb(0, 8'h0c, 0); check("standby status", q, 32'h0);
      apb(1, 8'h00, 32'h47); run <= 1;
      #1 check("pin released", first_interrupt_pin_oe_n_o, 1);
      repeat (60) @(posedge clk_i);
      run <= 0;
      apb(0, 8'h0c, 0); check("ext clock sample", q, 32'h5);
      apb(1, 8'h00, 32'h0d); impact_lo_i <= 1;
      repeat (3) @(posedge clk_i);
      impact_lo_i <= 0;
      apb(0, 8'h08, 0); check("high threshold", q, 32'h22);
      impact_hi_i <= 1;
      @(posedge clk_i);
      impact_hi_i <= 0;
      apb(0, 8'h08, 0); check("impact wake", q, 32'h23);
      apb(1, 8'h00, 32'h16); apb(0, 8'h08, 0); check("wake sleep", q, 32'h06);
      #1 check("wake irq", irq_o, 0);
      repeat (105) @(posedge clk_i);
      apb(0, 8'h08, 0); check("wake settle", q, 32'h27);
      motion_i <= 1;
      @(posedge clk_i);
      motion_i <= 0;
      @(posedge clk_i);
      sample_i <= 12'h3c1;
      #1 check("host alert", host_alert_o, 1);
      repeat (30) @(posedge clk_i);
      #1 check("wake refresh", data_o, 12'h3c1);
      check("wake no fifo", fifo_wr_o, 0);
      apb(1, 8'h00, 32'h26); motion_i <= 1;
      repeat (110) @(posedge clk_i);
      #1 check("downstream wake", downstream_wake_o, 1);
      check("alert cleared", host_alert_o, 0);
      apb(1, 8'h00, 32'h06);
      repeat (110) @(posedge clk_i);
      apb(0, 8'h08, 0); check("motion to measure", q, 32'h23);
      motion_i <= 0;
      // standby first, then the trigger pin is reconfigured
      apb(1, 8'h00, 32'h00); apb(1, 8'h00, 32'h83);
      repeat (730) @(posedge clk_i);
      apb(0, 8'h08, 0); check("long settle", q, 32'h21);
      repeat (6) @(posedge clk_i);
      apb(0, 8'h08, 0); check("long settle end", q, 32'h23);
      sample_i <= 12'h1e7;
      sync_pin <= 1;
      #1 check("sync pin released", second_interrupt_pin_oe_n_o, 1);
      repeat (4) @(posedge clk_i);
      sync_pin <= 0;
      repeat (6) @(posedge clk_i);
      #1 check("sync sample", data_o, 12'h1e7);
      apb(0, 8'h0c, 0); check("sync status", q, 32'h5);
      #1 check("irq on first pin", first_interrupt_pin_o, 1);
      check("first pin driven", first_interrupt_pin_oe_n_o, 0);
      @(posedge clk_i);
      mosi_sda_i <= 1;
      #1 check("spi data route", spi_mosi_o, 1);
      @(posedge clk_i);
      i2c_sel_i <= 1;
      cs_scl_i <= 0;
      #1 check("sda share", i2c_sda_o, 1);
      check("scl share", i2c_scl_o, 0);
      check("spi select idle", spi_cs_n_o, 1);
      check("spi data parked", spi_mosi_o, 0);
      wrap_up();
   end
endmodule
